// ===== verilog/tmrpwm_top.v
// 8-bit timer: interval, PWM and carrier generator modes behind an APB slave.
// Assumes the count clock is CLOCK itself and the companion irq is asynchronous.
//
// Operation
// - Interval mode: period match raises interrupt and clears counter
// - Interval mode ignores duty compare completely
// - Run bit set starts counting, cleared stops it
// - PWM: period match clears counter, interrupts, output active, then compare duty
// - PWM: duty match makes output inactive, back to period, no clear
// - PWM period is N+1 clocks, active:inactive is M+1 : N-M
// - Duty write while running latched, applied at old-duty match after three clocks
// - Stopping forces interrupt and output inactive
// - Carrier: period times low width, duty times high width
// - Carrier: any match interrupts, clears, inverts, swaps compare; period first
// - Carrier output low if active enable zero; else high or carrier by select
// - Companion irq synchronised; pulse copies buffered to active enable
// - Carrier period N+M+2 clocks, high:low is M+1 : N+1
// - Carrier control resets to zero; select bit2, buffered bit1, active bit0
`timescale 1ns/10ps
`include "tmrpwm_consts.vh"

module tmrpwm_top
(
	input wire CLOCK,
	input wire RESET,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	input wire COMPANION_COUNTER_IRQ,
	output reg TIMER_MATCH_IRQ,
	output reg TIMER_OUT_PIN
);

// ----------------------------------------
// Declarations
// ----------------------------------------
reg run_control_bit_reg;
reg [1:0] mode_reg;
reg [7:0] period_compare_reg;
reg [7:0] duty_compare_reg;
reg [7:0] duty_latch_reg;
reg duty_pending_reg;
reg [1:0] duty_age_reg;
reg carrier_select_reg;
reg buffered_output_enable_reg;
reg active_output_enable_reg;
reg [7:0] count_reg;
reg [7:0] count_next;
reg use_duty_reg;
reg use_duty_next;
reg wave_reg;
reg wave_next;
reg irq_next;
reg duty_load;
reg [31:0] rdata_next;
wire synced_gate_pulse;
wire setup_phase;
wire wr_en;
wire [7:0] cmp_value;
wire match;
reg addr_ok;

assign setup_phase = PSEL && !PENABLE;
// Write lands at the completing access edge only
assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
assign cmp_value = use_duty_reg ? duty_compare_reg : period_compare_reg;
assign match = run_control_bit_reg && (count_reg == cmp_value);

// ----------------------------------------
// Companion interrupt crossing
// ----------------------------------------
// Filtered three-flop chain, one pulse per rising edge
tmrpwm_sync u_sync
(
	.clk(CLOCK),
	.rst(RESET),
	.din(COMPANION_COUNTER_IRQ),
	.pulse(synced_gate_pulse)
);

// ----------------------------------------
// Address decode
// ----------------------------------------
always @*
begin
	case (PADDR)
		`TP_OFS_MODE, `TP_OFS_PERIOD, `TP_OFS_DUTY, `TP_OFS_CARRIER, `TP_OFS_STATUS:
			addr_ok = 1'b1;
		default:
			addr_ok = 1'b0;
	endcase
end

// ----------------------------------------
// APB handshake
// ----------------------------------------
// One wait-free access: ready rises in the access cycle after setup
always @(posedge CLOCK)
begin
	if (RESET)
	begin
		PREADY <= 1'b0;
		PSLVERR <= 1'b0;
		PRDATA <= 32'h00000000;
	end
	else
	begin
		PREADY <= setup_phase;
		PSLVERR <= setup_phase && !addr_ok;
		if (setup_phase && !PWRITE)
			PRDATA <= rdata_next;
	end
end

// Read mux; unmapped addresses read zero and flag an error
always @*
begin
	rdata_next = 32'h00000000;
	case (PADDR)
		`TP_OFS_MODE:
			rdata_next = {29'h0000000, mode_reg, run_control_bit_reg};
		`TP_OFS_PERIOD:
			rdata_next = {24'h000000, period_compare_reg};
		`TP_OFS_DUTY:
			rdata_next = {24'h000000, duty_pending_reg ? duty_latch_reg : duty_compare_reg};
		`TP_OFS_CARRIER:
			rdata_next = {29'h0000000, carrier_select_reg, buffered_output_enable_reg,
				active_output_enable_reg};
		`TP_OFS_STATUS:
			rdata_next = {22'h00000, duty_pending_reg, use_duty_reg, count_reg};
		default:
			rdata_next = 32'h00000000;
	endcase
end

// ----------------------------------------
// Control and compare registers
// ----------------------------------------
// Period is software's to keep steady while running
always @(posedge CLOCK)
begin
	if (RESET)
	begin
		run_control_bit_reg <= 1'b0;
		mode_reg <= `TP_MODE_INTERVAL;
		period_compare_reg <= `TP_RST_BYTE;
		carrier_select_reg <= 1'b0;
		buffered_output_enable_reg <= 1'b0;
	end
	else if (wr_en && !PSLVERR)
	begin
		case (PADDR)
			`TP_OFS_MODE:
			begin
				run_control_bit_reg <= PWDATA[`TP_MODE_RUN_BIT];
				mode_reg <= PWDATA[`TP_MODE_SEL_HI:`TP_MODE_SEL_LO];
			end
			`TP_OFS_PERIOD:
				period_compare_reg <= PWDATA[7:0];
			`TP_OFS_CARRIER:
			begin
				carrier_select_reg <= PWDATA[`TP_CAR_SELECT_BIT];
				buffered_output_enable_reg <= PWDATA[`TP_CAR_BUFFERED_BIT];
			end
			default:
				run_control_bit_reg <= run_control_bit_reg;
		endcase
	end
end

// Master/slave enable: active copy only moves on the synced pulse
always @(posedge CLOCK)
begin
	if (RESET)
		active_output_enable_reg <= 1'b0;
	else if (synced_gate_pulse)
		active_output_enable_reg <= buffered_output_enable_reg;
end

// ----------------------------------------
// Duty latch
// ----------------------------------------
// A duty write while running waits for the old-duty match and three clocks of age
always @*
begin
	duty_load = duty_pending_reg && match && use_duty_reg && (mode_reg != `TP_MODE_INTERVAL)
		&& (duty_age_reg == `TP_DUTY_SETTLE);
end

always @(posedge CLOCK)
begin
	if (RESET)
	begin
		duty_compare_reg <= `TP_RST_BYTE;
		duty_latch_reg <= `TP_RST_BYTE;
		duty_pending_reg <= 1'b0;
		duty_age_reg <= 2'h0;
	end
	else if (wr_en && !PSLVERR && (PADDR == `TP_OFS_DUTY))
	begin
		duty_latch_reg <= PWDATA[7:0];
		// Stopped timer takes the value at once, so a restart write is effective
		if (!run_control_bit_reg)
		begin
			duty_compare_reg <= PWDATA[7:0];
			duty_pending_reg <= 1'b0;
		end
		else
		begin
			duty_pending_reg <= 1'b1;
			duty_age_reg <= 2'h0;
		end
	end
	else if (duty_load)
	begin
		duty_compare_reg <= duty_latch_reg;
		duty_pending_reg <= 1'b0;
	end
	else if (duty_pending_reg && (duty_age_reg != `TP_DUTY_SETTLE))
		duty_age_reg <= duty_age_reg + 2'h1;
end

// ----------------------------------------
// Counter and compare sequencer
// ----------------------------------------
// Next-state of counter, compare select, waveform and interrupt
always @*
begin
	count_next = count_reg + 8'h01;
	use_duty_next = use_duty_reg;
	wave_next = wave_reg;
	irq_next = 1'b0;
	if (!run_control_bit_reg)
	begin
		// Stop parks everything so the next start compares period first
		count_next = 8'h00;
		use_duty_next = 1'b0;
		wave_next = 1'b0;
	end
	else if (match)
	begin
		case (mode_reg)
			`TP_MODE_PWM:
			begin
				if (!use_duty_reg)
				begin
					count_next = 8'h00;
					irq_next = 1'b1;
					wave_next = 1'b1;
					use_duty_next = 1'b1;
				end
				else
				begin
					// Counter runs on, so period stays N+1
					wave_next = 1'b0;
					use_duty_next = 1'b0;
				end
			end
			`TP_MODE_CARRIER:
			begin
				// Low lasts N+1, high lasts M+1
				count_next = 8'h00;
				irq_next = 1'b1;
				wave_next = !wave_reg;
				use_duty_next = !use_duty_reg;
			end
			default:
			begin
				// Interval: only period compared, duty never selected
				count_next = 8'h00;
				irq_next = 1'b1;
				use_duty_next = 1'b0;
			end
		endcase
	end
end

always @(posedge CLOCK)
begin
	if (RESET)
	begin
		count_reg <= 8'h00;
		use_duty_reg <= 1'b0;
		wave_reg <= 1'b0;
	end
	else
	begin
		count_reg <= count_next;
		use_duty_reg <= use_duty_next;
		wave_reg <= wave_next;
	end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
// Both outputs registered; a stopped timer drives both inactive
always @(posedge CLOCK)
begin
	if (RESET)
	begin
		TIMER_MATCH_IRQ <= 1'b0;
		TIMER_OUT_PIN <= 1'b0;
	end
	else
	begin
		TIMER_MATCH_IRQ <= irq_next && run_control_bit_reg;
		if (!run_control_bit_reg)
			TIMER_OUT_PIN <= 1'b0;
		else if (mode_reg == `TP_MODE_CARRIER)
			// Gated by the master enable and select
			TIMER_OUT_PIN <= active_output_enable_reg && (!carrier_select_reg || wave_next);
		else if (mode_reg == `TP_MODE_PWM)
			TIMER_OUT_PIN <= wave_next;
		else
			TIMER_OUT_PIN <= 1'b0;
	end
end

endmodule

// ===== inc/tmrpwm_consts.vh
// Constants for the 8-bit timer with PWM and carrier modes.
// Assumes a 32-bit APB slave with one register per aligned word.
`ifndef TMRPWM_CONSTS_VH
`define TMRPWM_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TP_OFS_MODE 12'h000
`define TP_OFS_PERIOD 12'h004
`define TP_OFS_DUTY 12'h008
`define TP_OFS_CARRIER 12'h00C
`define TP_OFS_STATUS 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TP_MODE_RUN_BIT 0
`define TP_MODE_SEL_LO 1
`define TP_MODE_SEL_HI 2
`define TP_CAR_ACTIVE_BIT 0
`define TP_CAR_BUFFERED_BIT 1
`define TP_CAR_SELECT_BIT 2

// ----------------------------------------
// Mode encodings
// ----------------------------------------
`define TP_MODE_INTERVAL 2'h0
`define TP_MODE_PWM 2'h1
`define TP_MODE_CARRIER 2'h2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TP_RST_BYTE 8'h00
`define TP_DUTY_SETTLE 2'h3

`endif

// ===== verilog/tmrpwm_sync.v
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes the input is asynchronous to CLOCK.
`timescale 1ns/10ps

module tmrpwm_sync
(
	input wire clk,
	input wire rst,
	input wire din,
	output reg pulse
);

reg s1_reg;
reg s2_reg;
reg s3_reg;
reg level_reg;

// ----------------------------------------
// Capture chain
// ----------------------------------------
// First stage feeds only the second; the level changes when stages two and three agree
always @(posedge clk)
begin
	if (rst)
	begin
		s1_reg <= 1'b0;
		s2_reg <= 1'b0;
		s3_reg <= 1'b0;
		level_reg <= 1'b0;
		pulse <= 1'b0;
	end
	else
	begin
		s1_reg <= din;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		if (s2_reg == s3_reg)
			level_reg <= s3_reg;
		pulse <= (s2_reg == s3_reg) && s3_reg && !level_reg;
	end
end

endmodule

// ===== test/tmrpwm_checker_asserts.sv
// Port checker for the timer: APB timing and output rules.
// Assumes register offsets from the shared header.
`timescale 1ns/10ps
`include "tmrpwm_consts.vh"

module tmrpwm_checker
(
	input wire CLOCK,
	input wire RESET,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [31:0] PRDATA,
	input wire PREADY,
	input wire PSLVERR,
	input wire COMPANION_COUNTER_IRQ,
	input wire TIMER_MATCH_IRQ,
	input wire TIMER_OUT_PIN
);
	// ----
	// Mode shadow
	// ----
	reg [2:0] mode_reg;
	wire wr_mode = PSEL && PENABLE && PREADY && PWRITE && PADDR == `TP_OFS_MODE;
	wire pwm_run = mode_reg == 3'h3;

	// Same edge as the slave write, so run timing lines up
	always @(posedge CLOCK)
	begin
		if (RESET)
			mode_reg <= 3'h0;
		else if (wr_mode)
			mode_reg <= PWDATA[2:0];
	end

	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);

	// ----
	// Properties
	// ----
	a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("ready missing after setup");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_err_unmapped: assert property (PSLVERR && !PWRITE |-> PREADY && PRDATA == 32'h0)
		else $error("bad refused read");
	a_irq_run: assert property (TIMER_MATCH_IRQ |-> $past(mode_reg[0]))
		else $error("irq while stopped");
	a_stop_quiet: assert property (wr_mode && !PWDATA[0] |-> ##2 !TIMER_OUT_PIN && !TIMER_MATCH_IRQ)
		else $error("outputs active after stop");
	a_idle_low: assert property (!mode_reg[0] && !$past(mode_reg[0]) |-> !TIMER_OUT_PIN)
		else $error("pin high while stopped");
	a_pwm_rise: assert property ($rose(TIMER_OUT_PIN) && pwm_run |-> TIMER_MATCH_IRQ)
		else $error("pwm rise without irq");
	a_pwm_fall: assert property ($fell(TIMER_OUT_PIN) && pwm_run |-> !TIMER_MATCH_IRQ)
		else $error("pwm fall with irq");
	c_pwm: cover property (pwm_run && $rose(TIMER_OUT_PIN));
	c_irq: cover property (TIMER_MATCH_IRQ);
	c_err: cover property (PSLVERR);
endmodule

bind tmrpwm_top tmrpwm_checker u_tmrpwm_checker
(
	.CLOCK(CLOCK),
	.RESET(RESET),
	.PSEL(PSEL),
	.PENABLE(PENABLE),
	.PWRITE(PWRITE),
	.PADDR(PADDR),
	.PWDATA(PWDATA),
	.PRDATA(PRDATA),
	.PREADY(PREADY),
	.PSLVERR(PSLVERR),
	.COMPANION_COUNTER_IRQ(COMPANION_COUNTER_IRQ),
	.TIMER_MATCH_IRQ(TIMER_MATCH_IRQ),
	.TIMER_OUT_PIN(TIMER_OUT_PIN)
);

// ===== test/tmrpwm_companion.sv
// Companion event counter model: one gate interrupt per call.
// Assumes the bench calls fire and supplies the timer clock; the line idles low.
`timescale 1ns/10ps

module tmrpwm_companion
(
	input wire clk,
	output logic irq
);
	initial irq = 1'b0;

	// Held six timer clocks so the synchroniser cannot miss it
	task fire;
		begin
			@(posedge clk);
			irq <= 1'b1;
			repeat (6) @(posedge clk);
			irq <= 1'b0;
		end
	endtask
endmodule

// ===== test/tmrpwm_tb.sv
// Bench for the timer: APB calls walk interval, PWM, carrier.
// Assumes the companion model drives the gate irq input.
`timescale 1ns/10ps
`include "tmrpwm_consts.vh"

module tmrpwm_tb;
	reg CLOCK = 1'b0;
	reg RESET = 1'b1;
	reg PSEL = 1'b0;
	reg PENABLE = 1'b0;
	reg PWRITE = 1'b0;
	reg [11:0] PADDR = 12'h0;
	reg [31:0] PWDATA = 32'h0;
	wire [31:0] PRDATA;
	wire PREADY;
	wire PSLVERR;
	wire COMPANION_COUNTER_IRQ;
	wire TIMER_MATCH_IRQ;
	wire TIMER_OUT_PIN;
	reg [31:0] rdat;
	reg rerr;
	integer error_cnt = 0;
	integer num_checks = 0;
	integer n;

	// 100 MHz clock
	always #5 CLOCK = ~CLOCK;

	tmrpwm_top u_tmrpwm_top
	(
		.CLOCK(CLOCK),
		.RESET(RESET),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.PRDATA(PRDATA),
		.PREADY(PREADY),
		.PSLVERR(PSLVERR),
		.COMPANION_COUNTER_IRQ(COMPANION_COUNTER_IRQ),
		.TIMER_MATCH_IRQ(TIMER_MATCH_IRQ),
		.TIMER_OUT_PIN(TIMER_OUT_PIN)
	);

	tmrpwm_companion u_tmrpwm_companion
	(
		.clk(CLOCK),
		.irq(COMPANION_COUNTER_IRQ)
	);

	// ----
	// Tasks
	// ----
	task complete_run;
		begin
			if (error_cnt == 0 && num_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	task bail;
		begin
			error_cnt = error_cnt + 1;
			complete_run;
		end
	endtask

	task check(input [31:0] g, input [31:0] e);
		begin
			num_checks = num_checks + 1;
			if (g !== e)
			begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED %0t got %0h exp %0h", $time, g, e);
			end
		end
	endtask

	// Request held until ready is seen high at a rising edge; answer taken at that edge
	task apb(input w, input [11:0] a, input [31:0] d);
		integer i;
		begin
			@(posedge CLOCK);
			PSEL <= 1'b1;
			PWRITE <= w;
			PADDR <= a;
			PWDATA <= d;
			@(posedge CLOCK);
			PENABLE <= 1'b1;
			@(posedge CLOCK);
			for (i = 0; i < 20 && PREADY !== 1'b1; i = i + 1)
				@(posedge CLOCK);
			if (PREADY !== 1'b1)
				bail;
			rdat = PRDATA;
			rerr = PSLVERR;
			// Released right after the completing edge; next call waits an edge first
			PSEL <= 1'b0;
			PENABLE <= 1'b0;
		end
	endtask

	function sv(input w);
		sv = w ? TIMER_MATCH_IRQ : TIMER_OUT_PIN;
	endfunction

	// Width in clocks of the next whole run at level v
	task span(input w, input v);
		integer i;
		begin
			@(negedge CLOCK);
			for (i = 0; i < 900 && sv(w) === v; i = i + 1)
				@(negedge CLOCK);
			for (i = i; i < 900 && sv(w) !== v; i = i + 1)
				@(negedge CLOCK);
			for (n = 0; n < 900 && sv(w) === v; n = n + 1)
				@(negedge CLOCK);
			if (i >= 900 || n >= 900)
				bail;
		end
	endtask

	// ----
	// Sequence
	// ----
	initial
	begin
		repeat (2) @(posedge CLOCK);
		RESET <= 1'b0;
		apb(0, `TP_OFS_CARRIER, 32'h0);
		check(rdat, 32'h0);
		apb(0, `TP_OFS_STATUS, 32'h0);
		check(rdat & 32'hFF, 32'h0);
		apb(0, 12'h014, 32'h0);
		check({31'h0, rerr}, 32'h1);
		// Interval: a duty below period must not shorten it
		apb(1, `TP_OFS_PERIOD, 32'h4);
		apb(1, `TP_OFS_DUTY, 32'h1);
		apb(1, `TP_OFS_MODE, 32'h1);
		span(1, 0);
		check(n, 32'h4);
		apb(1, `TP_OFS_MODE, 32'h0);
		apb(0, `TP_OFS_STATUS, 32'h0);
		check(rdat & 32'hFF, 32'h0);
		// PWM with period 9, duty 3: high from period match to duty match, M+1 wide
		apb(1, `TP_OFS_PERIOD, 32'h9);
		apb(1, `TP_OFS_DUTY, 32'h3);
		apb(1, `TP_OFS_MODE, 32'h3);
		span(0, 1);
		check(n, 32'h4);
		span(0, 0);
		check(n, 32'h6);
		span(1, 0);
		check(n, 32'h9);
		// Duty change in flight lands a period or two later
		apb(1, `TP_OFS_DUTY, 32'h5);
		apb(0, `TP_OFS_DUTY, 32'h0);
		check(rdat, 32'h5);
		repeat (3) span(0, 1);
		check(n, 32'h6);
		apb(1, `TP_OFS_MODE, 32'h0);
		repeat (3) @(negedge CLOCK);
		check({31'h0, TIMER_OUT_PIN}, 32'h0);
		// Carrier with select and buffered enable set first
		apb(1, `TP_OFS_CARRIER, 32'h6);
		apb(1, `TP_OFS_PERIOD, 32'h3);
		apb(1, `TP_OFS_DUTY, 32'h1);
		apb(1, `TP_OFS_MODE, 32'h5);
		u_tmrpwm_companion.fire;
		repeat (8) @(negedge CLOCK);
		apb(0, `TP_OFS_CARRIER, 32'h0);
		check(rdat, 32'h7);
		span(0, 1);
		check(n, 32'h2);
		span(0, 0);
		check(n, 32'h4);
		// Gate off, then steady high with select clear
		apb(1, `TP_OFS_CARRIER, 32'h4);
		u_tmrpwm_companion.fire;
		repeat (8) @(negedge CLOCK);
		check({31'h0, TIMER_OUT_PIN}, 32'h0);
		apb(1, `TP_OFS_MODE, 32'h0);
		apb(1, `TP_OFS_CARRIER, 32'h2);
		apb(1, `TP_OFS_DUTY, 32'h1);
		apb(1, `TP_OFS_MODE, 32'h5);
		u_tmrpwm_companion.fire;
		repeat (8) @(negedge CLOCK);
		check({31'h0, TIMER_OUT_PIN}, 32'h1);
		complete_run;
	end
endmodule
